//--- design/pllc_defines.svh
// Constants of the synthesizer standby and main divider control block
`ifndef PLLC_DEFINES_SVH
`define PLLC_DEFINES_SVH

// ==========================================================
// Serial word lengths
`define PLLC_LEN_CTRL      6'd8
`define PLLC_LEN_MAIN      6'd24
`define PLLC_LEN_MAX       6'd32

// ==========================================================
// Standby control register fields
`define PLLC_C_SEC_SLEEP   0
`define PLLC_C_MAIN_SLEEP  1
`define PLLC_C_OSC_SLEEP   2
`define PLLC_C_RESET       8'h03

// ==========================================================
// Main loop configuration register fields
`define PLLC_N_AUX_CTL     23
`define PLLC_N_LOCK_WIN    22
`define PLLC_N_PUMP_MSB    21
`define PLLC_N_PUMP_LSB    19
`define PLLC_N_PUMP_RATIO  18
`define PLLC_N_DIV_MSB     17
`define PLLC_N_RESET       24'h0003e0
`define PLLC_N_DIV_RESET   18'h003e0

// ==========================================================
// Decoded values
`define PLLC_LOCK_WIN_SHORT 8'h20
`define PLLC_LOCK_WIN_LONG  8'h80
`define PLLC_ADAPT_BASE     8'h10
`define PLLC_AUX_X2_20      5'h14
`define PLLC_AUX_X2_25      5'h19
`define PLLC_AUX_X2_16      5'h10

`endif

//--- design/pllc_pkg.sv
// Types of the synthesizer standby and main divider control block
package pllc_pkg;
    typedef enum logic [1:0] {
        PLLC_SLEEP = 2'b00,
        PLLC_ARM   = 2'b01,
        PLLC_RUN   = 2'b11
    } pllc_wake_state_t;
endpackage

//--- design/pllc_wake_if.sv
// Signals between the top and one loop standby sequencer
`timescale 1ns/1ps
`default_nettype none
interface pllc_wake_if;
    logic sleep;
    logic ref_pulse;
    logic div_en;
    logic pd_en;
    logic fb_load;
    logic det_reset;
    modport seq (input sleep, input ref_pulse,
                 output div_en, output pd_en, output fb_load,
                 output det_reset);
    modport ctl (output sleep, output ref_pulse,
                 input div_en, input pd_en, input fb_load,
                 input det_reset);
endinterface
`default_nettype wire

//--- design/pllc_serial_rx.sv
// Serial port receiver: shifts bits in, hands over whole words
`timescale 1ns/1ps
`default_nettype none
module pllc_serial_rx
    import pllc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        sclk,
    input  wire logic        sdata,
    input  wire logic        enable_b,
    output logic             word_valid,
    output logic [5:0]       word_len,
    output logic [23:0]      word_data
);
`include "pllc_defines.svh"

    logic        sclk_q;
    logic        enable_b_q;
    logic [23:0] shift;
    logic [5:0]  count;

    // ==========================================================
    // Edge history
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q     <= 1'b0;
            enable_b_q <= 1'b1;
        end else begin
            sclk_q     <= sclk;
            enable_b_q <= enable_b;
        end
    end

    // ==========================================================
    // Shift register, MSB first on rising serial clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift <= 24'h000000;
            count <= 6'h00;
        end else if (enable_b) begin
            count <= 6'h00;
        end else if (sclk && !sclk_q) begin
            shift <= {shift[22:0], sdata};
            if (count != `PLLC_LEN_MAX) begin
                count <= count + 6'h01;
            end
        end
    end

    // ==========================================================
    // Word handed over when enable rises
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            word_valid <= 1'b0;
            word_len   <= 6'h00;
            word_data  <= 24'h000000;
        end else begin
            word_valid <= enable_b && !enable_b_q;
            if (enable_b && !enable_b_q) begin
                word_len  <= count;
                word_data <= shift;
            end
        end
    end
endmodule
`default_nettype wire

//--- design/pllc_loop_wake.sv
// Two-step standby exit sequencer for one loop
`timescale 1ns/1ps
`default_nettype none
module pllc_loop_wake
    import pllc_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_b,
    pllc_wake_if.seq   wif
);
    pllc_wake_state_t state;

    // ==========================================================
    // Sleep, armed with pulses blocked, running
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= PLLC_SLEEP;
        end else if (wif.sleep) begin
            state <= PLLC_SLEEP;
        end else begin
            unique case (state)
                PLLC_SLEEP: state <= PLLC_ARM;
                PLLC_ARM: begin
                    if (wif.ref_pulse) begin
                        state <= PLLC_RUN;
                    end
                end
                PLLC_RUN: state <= PLLC_RUN;
                default:  state <= PLLC_SLEEP;
            endcase
        end
    end

    always_comb begin
        wif.div_en = (state != PLLC_SLEEP);
        wif.pd_en  = (state == PLLC_RUN);
        // load and reset on first reference pulse
        wif.fb_load   = (state == PLLC_ARM) && wif.ref_pulse && !wif.sleep;
        wif.det_reset = wif.fb_load;
    end
endmodule
`default_nettype wire

//--- design/pllc_top.sv
// Standby and main loop configuration control of a dual synthesizer
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Main sleep bit set puts the main loop into standby.
// - Main standby floats both pumps, stops dividers, amp, bias, detector.
// - Main standby leaves oscillator running; only oscillator sleep stops it.
// - Main wake first enables amp, dividers, bias with detector pulses blocked.
// - Next reference pulse loads divider, resets detectors, then passes pulses.
// - Registers keep contents and stay writable in standby.
// - Secondary sleep floats its pump, stops amp and dividers.
// - Mode low keeps secondary prescaler and aux output until oscillator sleeps.
// - Secondary wake uses the same two steps as the main loop.
// - Aux control and two secondary bits select aux output ratio.
// - Lock window select gives 32 or 128 oscillator periods.
// - Pump codes 0 to 3 select float, low, high or both pumps.
// - Pump codes 4 to 7 run high pump 16..128 reference cycles, then low.
// - Pump ratio bit selects 4:1 or 8:1 by reducing low pump current.
// - Feedback divide is an 18-bit binary value, host keeps 992..262143.
module pllc_top
    import pllc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        SER_CLK,
    input  wire logic        SER_DATA,
    input  wire logic        SER_ENABLE_B,
    input  wire logic        MODE_PIN,
    input  wire logic [1:0]  SEC_REF_LOW_BITS,
    input  wire logic        MAIN_REF_DIV_PULSE,
    input  wire logic        SEC_REF_DIV_PULSE,
    output logic             OSC_EN,
    output logic             MAIN_DIV_EN,
    output logic             MAIN_DET_EN,
    output logic             MAIN_FB_LOAD,
    output logic             MAIN_DET_RESET,
    output logic             HIGH_PUMP_EN,
    output logic             LOW_PUMP_EN,
    output logic             LOW_PUMP_REDUCED,
    output logic [17:0]      MAIN_FB_DIVIDE,
    output logic [7:0]       LOCK_WINDOW_PERIODS,
    output logic             SEC_DIV_EN,
    output logic             SEC_DET_EN,
    output logic             SEC_FB_LOAD,
    output logic             SEC_DET_RESET,
    output logic             SEC_PUMP_EN,
    output logic             SEC_PRESCALER_EN,
    output logic             AUX_OUT_EN,
    output logic [4:0]       AUX_RATIO_X2
);
`include "pllc_defines.svh"

    logic        rst_q1;
    logic        rst_b;
    logic        word_valid;
    logic [5:0]  word_len;
    logic [23:0] word_data;
    logic [7:0]  loop_standby_control;
    logic [23:0] main_loop_config;
    logic        main_sleep_bit;
    logic        secondary_sleep_bit;
    logic        oscillator_sleep_bit;
    logic [2:0]  pump_select;
    logic [7:0]  adapt_count;
    logic [7:0]  adapt_limit;
    logic        adapt_done;
    logic        next_high;
    logic        next_low;

    pllc_wake_if main_wif ();
    pllc_wake_if sec_wif ();

    // ==========================================================
    // Reset release
    // Both flops clear together; release follows two edges later
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_q1 <= 1'b0;
            rst_b  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_b  <= rst_q1;
        end
    end

    // ==========================================================
    // Serial port
    // Receiver hands over a word only when its frame ends
    pllc_serial_rx u_rx (
        .clk        (CLK),
        .rst_b      (rst_b),
        .sclk       (SER_CLK),
        .sdata      (SER_DATA),
        .enable_b   (SER_ENABLE_B),
        .word_valid (word_valid),
        .word_len   (word_len),
        .word_data  (word_data)
    );

    // ==========================================================
    // Registers
    // Word length picks the target; any other length is dropped
    // writes accepted regardless of standby
    always_ff @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            loop_standby_control <= `PLLC_C_RESET;
        end else if (word_valid && word_len == `PLLC_LEN_CTRL) begin
            loop_standby_control <= word_data[7:0];
        end
    end

    // applied only on a complete word
    always_ff @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            main_loop_config <= `PLLC_N_RESET;
        end else if (word_valid && word_len == `PLLC_LEN_MAIN) begin
            main_loop_config <= word_data;
        end
    end

    // Field views of the two registers
    assign main_sleep_bit       = loop_standby_control[`PLLC_C_MAIN_SLEEP];
    assign secondary_sleep_bit  = loop_standby_control[`PLLC_C_SEC_SLEEP];
    assign oscillator_sleep_bit = loop_standby_control[`PLLC_C_OSC_SLEEP];
    assign pump_select = main_loop_config[`PLLC_N_PUMP_MSB:`PLLC_N_PUMP_LSB];

    // ==========================================================
    // Loop standby sequencers
    // Each loop has its own copy of the same sequencer; only the sleep bit and the pulse source differ
    // main sleep bit drives main sequencer
    assign main_wif.sleep     = main_sleep_bit;
    assign main_wif.ref_pulse = MAIN_REF_DIV_PULSE;
    // secondary sleep bit drives its sequencer
    assign sec_wif.sleep      = secondary_sleep_bit;
    assign sec_wif.ref_pulse  = SEC_REF_DIV_PULSE;

    pllc_loop_wake u_main_wake (
        .clk   (CLK),
        .rst_b (rst_b),
        .wif   (main_wif)
    );

    pllc_loop_wake u_sec_wake (
        .clk   (CLK),
        .rst_b (rst_b),
        .wif   (sec_wif)
    );

    // ==========================================================
    // Adaptive pump timer, counts reference pulses after start
    // A main word or a stopped loop restarts the interval
    always_comb begin
        adapt_limit = `PLLC_ADAPT_BASE << pump_select[1:0];
    end

    // high pump interval of 16 to 128 reference cycles
    always_ff @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            adapt_count  <= 8'h00;
            adapt_done   <= 1'b0;
        end else begin
            if ((word_valid && word_len == `PLLC_LEN_MAIN)
                    || !main_wif.pd_en) begin
                adapt_count <= 8'h00;
                adapt_done  <= 1'b0;
            end else if (pump_select[2] && !adapt_done
                    && MAIN_REF_DIV_PULSE) begin
                adapt_count <= adapt_count + 8'h01;
                if (adapt_count + 8'h01 == adapt_limit) begin
                    adapt_done <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Main pump selection
    // Pumps stay floating while armed so no early correction escapes
    always_comb begin
        next_high = 1'b0;
        next_low  = 1'b0;
        if (main_wif.pd_en) begin
            unique case (pump_select)
                3'h0: begin
                    next_high = 1'b0;
                    next_low  = 1'b0;
                end
                3'h1: next_low = 1'b1;
                3'h2: next_high = 1'b1;
                3'h3: begin
                    next_high = 1'b1;
                    next_low  = 1'b1;
                end
                3'h4, 3'h5, 3'h6, 3'h7: begin
                    next_high = !adapt_done;
                    next_low  = adapt_done;
                end
            endcase
        end
    end

    // ==========================================================
    // Main loop outputs
    // Registered so pumps and detector switch on one clock edge
    always_ff @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            MAIN_DIV_EN    <= 1'b0;
            MAIN_DET_EN    <= 1'b0;
            MAIN_FB_LOAD   <= 1'b0;
            MAIN_DET_RESET <= 1'b0;
            HIGH_PUMP_EN   <= 1'b0;
            LOW_PUMP_EN    <= 1'b0;
        end else begin
            // dividers, amp, bias off in standby
            MAIN_DIV_EN    <= main_wif.div_en;
            MAIN_DET_EN    <= main_wif.pd_en;
            MAIN_FB_LOAD   <= main_wif.fb_load;
            MAIN_DET_RESET <= main_wif.det_reset;
            HIGH_PUMP_EN   <= next_high;
            LOW_PUMP_EN    <= next_low;
        end
    end

    // ==========================================================
    // Decoded main configuration
    // Register only changes on a whole word, so copying each cycle is safe
    always_ff @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            LOW_PUMP_REDUCED    <= 1'b0;
            MAIN_FB_DIVIDE      <= `PLLC_N_DIV_RESET;
            LOCK_WINDOW_PERIODS <= `PLLC_LOCK_WIN_SHORT;
        end else begin
            // ratio bit reduces low pump current
            LOW_PUMP_REDUCED <= main_loop_config[`PLLC_N_PUMP_RATIO];
            // divide value passed as plain binary
            MAIN_FB_DIVIDE   <= main_loop_config[`PLLC_N_DIV_MSB:0];
            LOCK_WINDOW_PERIODS <= main_loop_config[`PLLC_N_LOCK_WIN]
                ? `PLLC_LOCK_WIN_LONG : `PLLC_LOCK_WIN_SHORT;
        end
    end

    // ==========================================================
    // Secondary loop and reference outputs
    // In mode high the reference outputs also stop with the secondary loop
    always_ff @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            SEC_DIV_EN       <= 1'b0;
            SEC_DET_EN       <= 1'b0;
            SEC_FB_LOAD      <= 1'b0;
            SEC_DET_RESET    <= 1'b0;
            SEC_PUMP_EN      <= 1'b0;
            SEC_PRESCALER_EN <= 1'b0;
            AUX_OUT_EN       <= 1'b0;
            OSC_EN           <= 1'b0;
        end else begin
            // secondary dividers and amp stop in standby
            SEC_DIV_EN    <= sec_wif.div_en;
            SEC_DET_EN    <= sec_wif.pd_en;
            SEC_FB_LOAD   <= sec_wif.fb_load;
            SEC_DET_RESET <= sec_wif.det_reset;
            SEC_PUMP_EN   <= sec_wif.pd_en;
            // oscillator governed only by its own bit
            OSC_EN        <= !oscillator_sleep_bit;
            // prescaler and aux output follow oscillator in mode low
            if (!MODE_PIN) begin
                SEC_PRESCALER_EN <= !oscillator_sleep_bit;
                AUX_OUT_EN       <= !oscillator_sleep_bit;
            end else begin
                SEC_PRESCALER_EN <= sec_wif.div_en && !oscillator_sleep_bit;
                AUX_OUT_EN       <= sec_wif.div_en && !oscillator_sleep_bit;
            end
        end
    end

    // ==========================================================
    // Auxiliary output ratio, twice the ratio to keep 12.5
    // Secondary low bits are a level input, sampled every cycle
    always_ff @(posedge CLK or negedge rst_b) begin
        if (!rst_b) begin
            AUX_RATIO_X2 <= `PLLC_AUX_X2_16;
        end else begin
            // ratio from control bit and two secondary bits
            if (main_loop_config[`PLLC_N_AUX_CTL]) begin
                AUX_RATIO_X2 <= (SEC_REF_LOW_BITS == 2'b00)
                    ? `PLLC_AUX_X2_16 : `PLLC_AUX_X2_20;
            end else begin
                AUX_RATIO_X2 <= (SEC_REF_LOW_BITS == 2'b00)
                    ? `PLLC_AUX_X2_20 : `PLLC_AUX_X2_25;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/pllc_host_model.sv
// Host side model that writes words over the serial port
`timescale 1ns/1ps
`default_nettype none
module pllc_host_model (
    input  wire logic clk,
    input  wire logic mode,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_enable_b
);
    initial begin
        ser_clk      = 1'b0;
        ser_data     = 1'b1;
        ser_enable_b = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // ==========
    // Word transfer, most significant bit first
    task automatic send(input int n, input logic [31:0] w);
        if (n == 24 && mode) w[23] = 1'b1;
        if (n == 24 && w[17:0] < 18'd992) w[17:0] = 18'd992;
        if (n == 8 && w[2]) w[1:0] = 2'b11;
        tick(1);
        ser_enable_b = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            ser_data = w[i];
            tick(2);
            ser_clk = 1'b1;
            tick(2);
            ser_clk = 1'b0;
        end
        tick(2);
        ser_enable_b = 1'b1;
        tick(1);
        // Released data line does not keep its last level
        ser_data = ~ser_data;
        tick(4);
    endtask
endmodule
`default_nettype wire

//--- tb/pllc_top_chk.sv
// Port checker of the standby and main divider control
`timescale 1ns/1ps
`default_nettype none
module pllc_top_chk (
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        SER_ENABLE_B,
    input wire logic        MODE_PIN,
    input wire logic [1:0]  SEC_REF_LOW_BITS,
    input wire logic        MAIN_REF_DIV_PULSE,
    input wire logic        MAIN_DIV_EN,
    input wire logic        MAIN_DET_EN,
    input wire logic        MAIN_FB_LOAD,
    input wire logic        MAIN_DET_RESET,
    input wire logic        HIGH_PUMP_EN,
    input wire logic        LOW_PUMP_EN,
    input wire logic [17:0] MAIN_FB_DIVIDE,
    input wire logic [7:0]  LOCK_WINDOW_PERIODS,
    input wire logic        SEC_DIV_EN,
    input wire logic        SEC_DET_EN,
    input wire logic        SEC_FB_LOAD,
    input wire logic        SEC_DET_RESET,
    input wire logic        SEC_PUMP_EN,
    input wire logic [4:0]  AUX_RATIO_X2
);
    logic [2:0] rdy;

    // Covers the internal reset release delay
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdy <= 3'h0;
        end else begin
            rdy <= {rdy[1:0], 1'b1};
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rdy[2]);

    // ==========
    // Main loop standby and wake
    a_main_det_div: assert property (MAIN_DET_EN |-> MAIN_DIV_EN)
        else $error("main detector on while loop stopped");
    a_main_pump_off: assert property ((!MAIN_DIV_EN)[*2] |->
        !HIGH_PUMP_EN && !LOW_PUMP_EN)
        else $error("main pump driving in standby");
    a_main_wake_block: assert property ($rose(MAIN_DIV_EN) |->
        !MAIN_DET_EN)
        else $error("pulses passed at first wake step");
    a_main_load_pair: assert property (MAIN_FB_LOAD |->
        MAIN_DET_RESET && !MAIN_DET_EN ##1 MAIN_DET_EN && !MAIN_FB_LOAD)
        else $error("main load without detector reset");
    a_main_arm_load: assert property (MAIN_REF_DIV_PULSE && MAIN_DIV_EN
        && !MAIN_DET_EN && !MAIN_FB_LOAD |-> ##[1:2] MAIN_FB_LOAD)
        else $error("main divider not loaded on pulse");

    // ==========
    // Secondary loop and decoded fields
    a_sec_pump_off: assert property (SEC_PUMP_EN |-> SEC_DIV_EN)
        else $error("secondary pump driving in standby");
    a_sec_load_pair: assert property (SEC_FB_LOAD |->
        SEC_DET_RESET && !SEC_DET_EN ##1 SEC_DET_EN && !SEC_FB_LOAD)
        else $error("secondary load without detector reset");
    a_lock_window: assert property (LOCK_WINDOW_PERIODS == 8'h20 ||
        LOCK_WINDOW_PERIODS == 8'h80)
        else $error("lock window out of set");
    a_aux_ratio: assert property (!MODE_PIN && SEC_REF_LOW_BITS != 2'b00
        && $past(SEC_REF_LOW_BITS) != 2'b00 |-> AUX_RATIO_X2 != 5'h10)
        else $error("aux ratio eight with low bits set");
    a_div_frame: assert property ((!SER_ENABLE_B)[*5] |->
        $stable(MAIN_FB_DIVIDE))
        else $error("divide changed inside a frame");

    c_main_load: cover property (MAIN_FB_LOAD);
    c_sec_load: cover property (SEC_FB_LOAD);
    c_adapt_end: cover property ($fell(HIGH_PUMP_EN) && LOW_PUMP_EN);
endmodule

bind pllc_top pllc_top_chk pllc_top_chk_inst (.*);
`default_nettype wire

//--- tb/pllc_top_tb.sv
// Self-checking testbench of the standby and main divider control
`timescale 1ns/1ps
`default_nettype none
module pllc_top_tb;
    logic        CLK, RST_B, MODE_PIN, MAIN_REF_DIV_PULSE, SEC_REF_DIV_PULSE;
    logic        SER_CLK, SER_DATA, SER_ENABLE_B, OSC_EN, MAIN_DIV_EN;
    logic        MAIN_DET_EN, MAIN_FB_LOAD, MAIN_DET_RESET, HIGH_PUMP_EN;
    logic        LOW_PUMP_EN, LOW_PUMP_REDUCED, SEC_DIV_EN, SEC_DET_EN;
    logic        SEC_FB_LOAD, SEC_DET_RESET, SEC_PUMP_EN, SEC_PRESCALER_EN;
    logic        AUX_OUT_EN;
    logic [1:0]  SEC_REF_LOW_BITS;
    logic [17:0] MAIN_FB_DIVIDE;
    logic [7:0]  LOCK_WINDOW_PERIODS;
    logic [4:0]  AUX_RATIO_X2;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;

    pllc_top pllc_top_inst (.*);
    pllc_host_model pllc_host_model_inst (.clk(CLK), .mode(MODE_PIN),
        .ser_clk(SER_CLK), .ser_data(SER_DATA), .ser_enable_b(SER_ENABLE_B));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    // ==========
    // Helpers
    task automatic final_report();
        $display("Checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic wr(input int n, input logic [31:0] w);
        pllc_host_model_inst.send(n, w);
    endtask

    task automatic pulse(input bit sec);
        {SEC_REF_DIV_PULSE, MAIN_REF_DIV_PULSE} = sec ? 2'b10 : 2'b01;
        tick(1);
        {SEC_REF_DIV_PULSE, MAIN_REF_DIV_PULSE} = 2'b00;
        tick(1);
    endtask

    // Wake of one loop: enabled but blocked, loaded on the next pulse
    task automatic wake(input bit sec);
        chk("div_en", 1, sec ? SEC_DIV_EN : MAIN_DIV_EN);
        chk("det_en", 0, sec ? SEC_DET_EN : MAIN_DET_EN);
        {SEC_REF_DIV_PULSE, MAIN_REF_DIV_PULSE} = sec ? 2'b10 : 2'b01;
        tick(1);
        {SEC_REF_DIV_PULSE, MAIN_REF_DIV_PULSE} = 2'b00;
        // Load and detector reset stand one cycle, pulses still blocked
        chk("fb_load", 1, sec ? SEC_FB_LOAD : MAIN_FB_LOAD);
        chk("det_rst", 1, sec ? SEC_DET_RESET : MAIN_DET_RESET);
        chk("det_en", 0, sec ? SEC_DET_EN : MAIN_DET_EN);
        tick(1);
        chk("fb_load", 0, sec ? SEC_FB_LOAD : MAIN_FB_LOAD);
        chk("det_rst", 0, sec ? SEC_DET_RESET : MAIN_DET_RESET);
        chk("det_en", 1, sec ? SEC_DET_EN : MAIN_DET_EN);
    endtask

    // ==========
    // Main sequence
    initial begin
        RST_B = 1'b0;
        MODE_PIN = 1'b0;
        MAIN_REF_DIV_PULSE = 1'b0;
        SEC_REF_DIV_PULSE = 1'b0;
        SEC_REF_LOW_BITS = 2'b00;
        tick(6);
        RST_B = 1'b1;
        tick(4);
        chk("osc_en", 1, OSC_EN);
        chk("main_div", 0, MAIN_DIV_EN);
        chk("sec_div", 0, SEC_DIV_EN);
        chk("presc_en", 1, SEC_PRESCALER_EN);
        chk("aux_en", 1, AUX_OUT_EN);
        chk("divide", 992, MAIN_FB_DIVIDE);
        // Config while asleep, then a short word that must be ignored
        wr(24, 32'hd803e8);
        chk("divide", 1000, MAIN_FB_DIVIDE);
        chk("lock_win", 128, LOCK_WINDOW_PERIODS);
        chk("high_pump", 0, HIGH_PUMP_EN);
        chk("low_pump", 0, LOW_PUMP_EN);
        wr(23, 32'h0003ff);
        chk("divide", 1000, MAIN_FB_DIVIDE);
        wr(8, 32'h01);
        wake(0);
        for (int c = 0; c < 4; c++) begin
            wr(24, {1'b1, 1'b0, c[2:0], c[0], 18'd1000});
            chk("high_pump", c[1], HIGH_PUMP_EN);
            chk("low_pump", c[0], LOW_PUMP_EN);
            chk("low_reduced", c[0], LOW_PUMP_REDUCED);
            chk("lock_win", 32, LOCK_WINDOW_PERIODS);
        end
        // Adaptive codes: high pump first, low pump after the count
        for (int k = 0; k < 4; k++) begin
            wr(24, {3'b101, k[1:0], 1'b0, 18'd1000});
            chk("high_pump", 1, HIGH_PUMP_EN);
            chk("low_pump", 0, LOW_PUMP_EN);
            repeat ((16 << k) - 1) pulse(0);
            tick(3);
            chk("high_pump", 1, HIGH_PUMP_EN);
            pulse(0);
            tick(3);
            chk("high_pump", 0, HIGH_PUMP_EN);
            chk("low_pump", 1, LOW_PUMP_EN);
        end
        wr(8, 32'h00);
        wake(1);
        chk("sec_pump", 1, SEC_PUMP_EN);
        for (int a = 0; a < 8; a++) begin
            if (a % 4 == 0) wr(24, {a[2], 23'h1803e8});
            SEC_REF_LOW_BITS = a[1:0];
            tick(3);
            chk("aux_x2", a[1:0] == 0 ? (a[2] ? 16 : 20) : (a[2] ? 20 : 25),
                AUX_RATIO_X2);
        end
        chk("high_pump", 1, HIGH_PUMP_EN);
        wr(8, 32'h03);
        chk("main_div", 0, MAIN_DIV_EN);
        chk("high_pump", 0, HIGH_PUMP_EN);
        chk("low_pump", 0, LOW_PUMP_EN);
        chk("sec_pump", 0, SEC_PUMP_EN);
        chk("osc_en", 1, OSC_EN);
        chk("presc_en", 1, SEC_PRESCALER_EN);
        chk("divide", 1000, MAIN_FB_DIVIDE);
        // Mode high: reference outputs follow the sleeping secondary loop
        MODE_PIN = 1'b1;
        wr(24, 32'h0803e8);
        chk("presc_en", 0, SEC_PRESCALER_EN);
        chk("aux_en", 0, AUX_OUT_EN);
        chk("aux_x2", 20, AUX_RATIO_X2);
        MODE_PIN = 1'b0;
        wr(8, 32'h04);
        chk("osc_en", 0, OSC_EN);
        chk("presc_en", 0, SEC_PRESCALER_EN);
        chk("aux_en", 0, AUX_OUT_EN);
        final_report();
    end
endmodule
`default_nettype wire
